/* src/gpx_expander.sv */
// Purpose: Eight-pin I/O expander, a two-wire bus target
// Assumes: linkClk oversamples SCL; pins are asynchronous
// Notes:   Bus logic on linkClk, pin logic on ref_clk
`timescale 1ns/1ps
`include "gpx_consts.svh"
module gpx_expander (
    input  wire logic       ref_clk,       // Pin side clock
    input  wire logic       rst,           // Async reset, active high
    input  wire logic       linkClk,       // Bus sampling clock
    input  wire logic       sclIn,         // Serial clock level
    input  wire logic       sdaIn,         // Serial data level
    output logic            sdaOut,        // Serial data drive value
    output logic            sdaOe,         // Serial data pull-down enable
    input  wire logic [2:0] addrStrapPins, // Address straps
    input  wire logic [7:0] portPinsIn,    // Port pin levels
    output logic      [7:0] portPinsOut,   // Port drive levels
    output logic      [7:0] portPinsOe,    // Port drive enables
    output logic            intOut,        // Interrupt drive value
    output logic            intOe          // Interrupt pull-down enable
);
    import gpx_pkg::*;

    localparam int CFG_W = $bits(gpx_cfg_t);

    gpx_link_t l_r;
    gpx_link_t l_nxt;
    gpx_core_t c_r;
    gpx_core_t c_nxt;
    gpx_cfg_t  cfgQ;
    logic [4:0] linkF;
    logic [7:0] pinsF;
    logic [2:0] strap;
    logic       scl;
    logic       sda;
    logic       sclRise;
    logic       sclFall;
    logic       startEv;
    logic       stopEv;
    logic       addrHit;
    logic [7:0] pinsL;
    logic [7:0] rdVal;

    gpx_word_if #(.W(CFG_W)) cfgX ();
    gpx_word_if #(.W(8))     pinX ();

    // Register read mux, shared by first and following read bytes
    function automatic logic [7:0] regRead(input logic [1:0] sel,
                                           input logic [7:0] pins,
                                           input logic [7:0] inv,
                                           input logic [7:0] out,
                                           input logic [7:0] dir);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            `GPX_SEL_IN:  v = pins ^ inv;
            `GPX_SEL_OUT: v = out;
            `GPX_SEL_INV: v = inv;
            `GPX_SEL_DIR: v = dir;
        endcase
        return v;
    endfunction

    // Bus pins and straps are asynchronous to linkClk
    gpx_pin_filter #(.W(5), .RST_VAL(5'h1f)) u_linkFilt (
        .clk (linkClk),
        .rst (rst),
        .d   ({addrStrapPins, sclIn, sdaIn}),
        .q   (linkF)
    );

    gpx_pin_filter #(.W(8), .RST_VAL(`GPX_PINS_RST)) u_pinFilt (
        .clk (ref_clk),
        .rst (rst),
        .d   (portPinsIn),
        .q   (pinsF)
    );

    // Register contents and read snapshots travel to the pin side
    gpx_word_cdc #(.W(CFG_W)) u_cfgCdc (
        .srcClk (linkClk),
        .dstClk (ref_clk),
        .rst    (rst),
        .port   (cfgX)
    );

    // Live pin levels travel to the bus side for input reads
    gpx_word_cdc #(.W(8)) u_pinCdc (
        .srcClk (ref_clk),
        .dstClk (linkClk),
        .rst    (rst),
        .port   (pinX)
    );

    assign strap = linkF[4:2];
    assign scl   = linkF[1];
    assign sda   = linkF[0];
    assign pinsL = pinX.q;
    assign cfgQ  = gpx_cfg_t'(cfgX.q);

    // Bus conditions from filtered levels
    assign sclRise = scl & ~l_r.sclP;
    assign sclFall = ~scl & l_r.sclP;
    assign startEv = scl & l_r.sclP & l_r.sdaP & ~sda;
    assign stopEv  = scl & l_r.sclP & ~l_r.sdaP & sda;
    assign addrHit = l_r.sh[7:1] == {`GPX_ADDR_HI, strap};
    assign rdVal   = regRead(l_r.cmd[1:0], pinsL, l_r.inv, l_r.out, l_r.dir);

    assign cfgX.data = {l_r.pendClr, l_r.snap, l_r.out, l_r.inv, l_r.dir};
    assign cfgX.load = (l_r.pendLoad | l_r.pendClr) & ~cfgX.busy;

    // Bus target machine; start and stop override any state
    always_comb begin
        l_nxt      = l_r;
        l_nxt.sclP = scl;
        l_nxt.sdaP = sda;
        if (cfgX.load) begin
            l_nxt.pendLoad = 1'b0;
            l_nxt.pendClr  = 1'b0;
        end
        if (startEv) begin
            l_nxt.st     = ST_RECV;
            l_nxt.ph     = PH_ADDR;
            l_nxt.bitCnt = 4'h0;
            l_nxt.sdaOe  = 1'b0;
        end else if (stopEv) begin
            l_nxt.st    = ST_IDLE;
            l_nxt.sdaOe = 1'b0;
        end else begin
            unique case (l_r.st)
                ST_IDLE: begin
                end
                ST_RECV: begin
                    if (sclRise) begin
                        l_nxt.sh     = {l_r.sh[6:0], sda};
                        l_nxt.bitCnt = 4'(l_r.bitCnt + 4'h1);
                    end else if (sclFall &&
                                 l_r.bitCnt == `GPX_BYTE_BITS) begin
                        l_nxt.bitCnt = 4'h0;
                        l_nxt.sdaOe  = 1'b1;
                        l_nxt.st     = ST_ACK;
                        unique case (l_r.ph)
                            PH_ADDR: begin
                                l_nxt.rw = l_r.sh[0];
                                if (!addrHit) begin
                                    // Foreign traffic is not tracked
                                    l_nxt.sdaOe = 1'b0;
                                    l_nxt.st    = ST_IDLE;
                                end
                            end
                            PH_CMD: begin
                                l_nxt.cmd = l_r.sh;
                            end
                            PH_DATA: begin
                                l_nxt.pendLoad = 1'b1;
                                unique case (l_r.cmd[1:0])
                                    `GPX_SEL_IN: begin
                                        l_nxt.pendLoad = 1'b0;
                                    end
                                    `GPX_SEL_OUT: l_nxt.out = l_r.sh;
                                    `GPX_SEL_INV: l_nxt.inv = l_r.sh;
                                    `GPX_SEL_DIR: l_nxt.dir = l_r.sh;
                                endcase
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Low held until the ninth clock falls again
                    if (sclFall) begin
                        l_nxt.sdaOe = 1'b0;
                        if (l_r.ph == PH_ADDR && l_r.rw) begin
                            l_nxt.sh    = rdVal;
                            l_nxt.sdaOe = ~rdVal[7];
                            l_nxt.st    = ST_SEND;
                        end else begin
                            l_nxt.st = ST_RECV;
                            l_nxt.ph = (l_r.ph == PH_ADDR) ? PH_CMD
                                                           : PH_DATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (sclFall) begin
                        if (l_r.bitCnt == `GPX_LAST_BIT) begin
                            l_nxt.sdaOe  = 1'b0;
                            l_nxt.bitCnt = 4'h0;
                            l_nxt.st     = ST_MACK;
                        end else begin
                            l_nxt.sh     = {l_r.sh[6:0], 1'b0};
                            l_nxt.sdaOe  = ~l_r.sh[6];
                            l_nxt.bitCnt = 4'(l_r.bitCnt + 4'h1);
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        l_nxt.nack = sda;
                        if (l_r.cmd[1:0] == `GPX_SEL_IN) begin
                            l_nxt.pendClr = 1'b1;
                            l_nxt.snap    = pinsL;
                        end
                    end else if (sclFall) begin
                        if (l_r.nack) begin
                            l_nxt.st = ST_IDLE;
                        end else begin
                            l_nxt.sh    = rdVal;
                            l_nxt.sdaOe = ~rdVal[7];
                            l_nxt.st    = ST_SEND;
                        end
                    end
                end
            endcase
        end
    end

    // Bus side registers and defaults
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            l_r          <= '0;
            l_r.sclP     <= 1'b1;
            l_r.sdaP     <= 1'b1;
            l_r.st       <= ST_IDLE;
            l_r.ph       <= PH_ADDR;
            l_r.out      <= `GPX_OUT_RST;
            l_r.inv      <= `GPX_INV_RST;
            l_r.dir      <= `GPX_DIR_RST;
            l_r.snap     <= `GPX_PINS_RST;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign pinX.data = pinsF;
    assign pinX.load = (pinsF != c_r.sent) & ~pinX.busy;

    // Pin side: drivers, snapshot and interrupt compare
    always_comb begin
        c_nxt = c_r;
        if (pinX.load) begin
            c_nxt.sent = pinsF;
        end
        if (cfgX.stb) begin
            c_nxt.out = cfgQ.out;
            c_nxt.dir = cfgQ.dir;
            c_nxt.oe  = ~cfgQ.dir;
            if (cfgQ.clr) begin
                c_nxt.snap = cfgQ.snap;
            end
        end
        // Filter still shows its reset level when primed rises, so the
        // snapshot waits one more cycle, marked by prime wrapping to zero
        if (!c_r.primed) begin
            c_nxt.prime  = 2'(c_r.prime + 2'h1);
            c_nxt.primed = c_r.prime == `GPX_PRIME_CNT;
        end else if (c_r.prime == 2'h0) begin
            c_nxt.prime = 2'h1;
            c_nxt.snap  = pinsF;
        end
        // Only input pins compare; a fresh input may differ at once
        c_nxt.intAct = c_r.primed & (c_r.prime != 2'h0) &
                       (|((pinsF ^ c_nxt.snap) & c_nxt.dir));
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            c_r      <= '0;
            c_r.out  <= `GPX_OUT_RST;
            c_r.dir  <= `GPX_DIR_RST;
            c_r.snap <= `GPX_PINS_RST;
        end else begin
            c_r <= c_nxt;
        end
    end

    // Open-drain pins only ever pull low
    assign sdaOut      = 1'b0;
    assign sdaOe       = l_r.sdaOe;
    assign intOut      = 1'b0;
    assign intOe       = c_r.intAct;
    assign portPinsOut = c_r.out;
    assign portPinsOe  = c_r.oe;

    // Pin side checks
    a_input_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (portPinsOe & c_r.dir) == 8'h00)
        else $error("input pin is driven");
    a_out_follow_cfg: assert property (@(posedge ref_clk) disable iff (rst)
        cfgX.stb |=> portPinsOut == $past(cfgQ.out))
        else $error("output level not taken from register");
    a_int_on_diff: assert property (@(posedge ref_clk) disable iff (rst)
        c_r.primed && c_r.prime != 2'h0 && !cfgX.stb &&
        |((pinsF ^ c_r.snap) & c_r.dir)
        |=> intOe)
        else $error("input change did not interrupt");
    a_int_clear_snap: assert property (@(posedge ref_clk) disable iff (rst)
        cfgX.stb && cfgQ.clr |=> c_r.snap == $past(cfgQ.snap))
        else $error("snapshot not taken on input read");
    a_out_no_int: assert property (@(posedge ref_clk) disable iff (rst)
        !(|((pinsF ^ c_nxt.snap) & c_nxt.dir)) |=> !intOe)
        else $error("interrupt without input difference");

    // Bus side checks
    a_start_to_addr: assert property (@(posedge linkClk) disable iff (rst)
        startEv |=> l_r.st == ST_RECV && l_r.ph == PH_ADDR &&
                    l_r.bitCnt == 4'h0)
        else $error("start not detected");
    a_stop_to_idle: assert property (@(posedge linkClk) disable iff (rst)
        stopEv |=> l_r.st == ST_IDLE && !sdaOe)
        else $error("stop did not return to idle");
    a_ack_low_high: assert property (@(posedge linkClk) disable iff (rst)
        l_r.st == ST_ACK && !startEv && !stopEv && scl |-> sdaOe)
        else $error("acknowledge released during clock high");
    a_addr_miss_idle: assert property (@(posedge linkClk) disable iff (rst)
        l_r.st == ST_RECV && l_r.ph == PH_ADDR && sclFall &&
        l_r.bitCnt == `GPX_BYTE_BITS && !addrHit && !startEv && !stopEv
        |=> l_r.st == ST_IDLE && !sdaOe)
        else $error("foreign address answered");
    a_cmd_stored: assert property (@(posedge linkClk) disable iff (rst)
        l_r.st == ST_RECV && l_r.ph == PH_CMD && sclFall &&
        l_r.bitCnt == `GPX_BYTE_BITS && !startEv && !stopEv
        |=> l_r.cmd == $past(l_r.sh) ##1 l_r.st == ST_ACK)
        else $error("command byte not stored");
    a_nack_release: assert property (@(posedge linkClk) disable iff (rst)
        l_r.st == ST_MACK && l_r.nack && sclFall && !startEv && !stopEv
        |=> l_r.st == ST_IDLE && !sdaOe)
        else $error("data line held after master nack");

    c_read_byte: cover property (@(posedge linkClk) disable iff (rst)
        l_r.st == ST_SEND ##[1:900] l_r.st == ST_MACK);
    c_write_data: cover property (@(posedge linkClk) disable iff (rst)
        l_r.ph == PH_DATA && l_r.st == ST_ACK);
    c_int_raised: cover property (@(posedge ref_clk) disable iff (rst)
        !intOe ##1 intOe);
    c_int_cleared: cover property (@(posedge ref_clk) disable iff (rst)
        intOe && cfgX.stb && cfgQ.clr ##1 !intOe);
endmodule // gpx_expander

/* include/gpx_consts.svh */
// Purpose: Shared constants of the octal I/O expander
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH
// Register select codes held in the low command bits
`define GPX_SEL_IN       2'h0
`define GPX_SEL_OUT      2'h1
`define GPX_SEL_INV      2'h2
`define GPX_SEL_DIR      2'h3
// Register reset values
`define GPX_OUT_RST      8'hff
`define GPX_INV_RST      8'h00
`define GPX_DIR_RST      8'hff
`define GPX_PINS_RST     8'hff
// Fixed upper target address bits
`define GPX_ADDR_HI      4'h7
// Bits per byte and last send index
`define GPX_BYTE_BITS    4'h8
`define GPX_LAST_BIT     4'h7
// Cycles before the first interrupt snapshot is trusted
`define GPX_PRIME_CNT    2'h3
`endif

/* include/gpx_pkg.sv */
// Purpose: Types of the octal I/O expander
// Assumes: Constants come from gpx_consts.svh
// Notes:   State machine codes are one-hot
package gpx_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_SEND = 5'b01000,
        ST_MACK = 5'b10000
    } gpx_bus_st_t;
    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_CMD  = 3'b010,
        PH_DATA = 3'b100
    } gpx_phase_t;
    // Word sent from the bus side to the pin side
    typedef struct packed {
        logic       clr;
        logic [7:0] snap;
        logic [7:0] out;
        logic [7:0] inv;
        logic [7:0] dir;
    } gpx_cfg_t;
    typedef struct packed {
        logic        sclP;
        logic        sdaP;
        gpx_bus_st_t st;
        gpx_phase_t  ph;
        logic [3:0]  bitCnt;
        logic [7:0]  sh;
        logic        rw;
        logic        nack;
        logic [7:0]  cmd;
        logic [7:0]  out;
        logic [7:0]  inv;
        logic [7:0]  dir;
        logic        sdaOe;
        logic        pendLoad;
        logic        pendClr;
        logic [7:0]  snap;
    } gpx_link_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] dir;
        logic [7:0] oe;
        logic [7:0] snap;
        logic [7:0] sent;
        logic [1:0] prime;
        logic       primed;
        logic       intAct;
    } gpx_core_t;
endpackage

/* include/gpx_word_if.sv */
// Purpose: Carrier of one word crossing between clock domains
// Assumes: Source holds load only while busy is low
// Notes:   q and stb belong to the destination clock
`timescale 1ns/1ps
interface gpx_word_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         load;
    logic         busy;
    logic [W-1:0] q;
    logic         stb;
    modport xing (input data, input load, output busy, output q, output stb);
    modport user (output data, output load, input busy, input q, input stb);
endinterface

/* src/gpx_pin_filter.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module gpx_pin_filter #(
    parameter int         W       = 8,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clk,    // Sampling clock
    input  wire logic         rst,    // Async reset, active high
    input  wire logic [W-1:0] d,      // Raw pins
    output logic      [W-1:0] q       // Filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gpx_filt_t;
    gpx_filt_t f_r;
    gpx_filt_t f_nxt;

    // Stage one feeds stage two only, so metastability stays contained
    always_comb begin
        f_nxt    = f_r;
        f_nxt.s1 = d;
        f_nxt.s2 = f_r.s1;
        f_nxt.s3 = f_r.s2;
        f_nxt.q  = (f_r.s2 & f_r.s3) | (f_r.q & (f_r.s2 ^ f_r.s3));
    end

    // Reset loads idle levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            f_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            f_r <= f_nxt;
        end
    end

    assign q = f_r.q;
endmodule // gpx_pin_filter

/* src/gpx_word_cdc.sv */
// Purpose: Toggle handshake that moves one word across clocks
// Assumes: Source waits for busy low before each load
// Notes:   Held word is stable while the toggle is in flight
`timescale 1ns/1ps
module gpx_word_cdc #(
    parameter int W = 8
) (
    input  wire logic srcClk,     // Source clock
    input  wire logic dstClk,     // Destination clock
    input  wire logic rst,        // Async reset, active high
    gpx_word_if.xing  port        // Word carrier
);
    typedef struct packed {
        logic [W-1:0] hold;
        logic         req;
        logic [1:0]   ackS;
    } gpx_src_t;
    typedef struct packed {
        logic [1:0]   reqS;
        logic         seen;
        logic [W-1:0] q;
        logic         stb;
    } gpx_dst_t;
    gpx_src_t s_r;
    gpx_src_t s_nxt;
    gpx_dst_t d_r;
    gpx_dst_t d_nxt;

    assign port.busy = s_r.req != s_r.ackS[1];
    assign port.q    = d_r.q;
    assign port.stb  = d_r.stb;

    // Source side: capture and toggle, then wait for the echo
    always_comb begin
        s_nxt      = s_r;
        s_nxt.ackS = {s_r.ackS[0], d_r.seen};
        if (port.load && !port.busy) begin
            s_nxt.hold = port.data;
            s_nxt.req  = ~s_r.req;
        end
    end

    always_ff @(posedge srcClk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Destination side: a toggle seen means the held word is settled
    always_comb begin
        d_nxt      = d_r;
        d_nxt.reqS = {d_r.reqS[0], s_r.req};
        d_nxt.stb  = 1'b0;
        if (d_r.reqS[1] != d_r.seen) begin
            d_nxt.seen = d_r.reqS[1];
            d_nxt.q    = s_r.hold;
            d_nxt.stb  = 1'b1;
        end
    end

    always_ff @(posedge dstClk or posedge rst) begin
        if (rst) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end
endmodule // gpx_word_cdc

/* test/gpx_bus_master.sv */
// Purpose: Two-wire bus master model
// Assumes: Each bus phase spans 10 clk cycles
// Notes:   SDA is only pulled low, never driven high
`timescale 1ns/1ps
module gpx_bus_master (
    input  wire logic clk,    // Pacing clock
    input  wire logic sda,    // SDA wire level
    output logic      scl,    // Serial clock
    output logic      sdaLow  // Pull SDA low
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // Phases outlast the target's input filter and answer delay
    task automatic q();
        repeat (10) @(posedge clk);
        #1;
    endtask
    // Start or repeated start: SDA falls with SCL high
    task automatic start();
        sdaLow = 1'b0;
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    // Nine slots MSB first, SDA moves with SCL low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sdaLow = ~tx[i];
            q();
            scl = 1'b1;
            q();
            rx[i] = sda;
            scl = 1'b0;
            q();
        end
    endtask
    // Stop: SDA rises with SCL high
    task automatic stop();
        sdaLow = 1'b1;
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b0;
        q();
    endtask
endmodule // gpx_bus_master

/* test/gpx_expander_test.sv */
// Purpose: Self-checking bench of the I/O expander
// Assumes: Straps tied to 5, so the target answers at 3d
// Notes:   Wire levels are resolved here from all enables
`timescale 1ns/1ps
module gpx_expander_test;
    localparam logic [6:0] ADDR = {4'h7, 3'h5};
    logic       refClk = 1'b0;
    logic       linkClk = 1'b0;
    logic       rst = 1'b1;
    logic       sclM, sdaLow, sdaOut, sdaOe, intOut, intOe;
    logic [7:0] ext = 8'h3c;
    logic [7:0] pinOut, pinOe;
    logic [8:0] rx;
    int         errors = 0;
    int         tests_run = 0;
    // Pull-ups win on SDA and INT wherever nobody pulls low; port pins take ext where not driven
    wire        sdaW = ~(sdaLow | (sdaOe & ~sdaOut));
    wire        intN = intOe ? intOut : 1'b1;
    wire  [7:0] pins = (pinOe & pinOut) | (~pinOe & ext);
    always #25 refClk = ~refClk;
    always #40 linkClk = ~linkClk;
    gpx_expander u_dut (.ref_clk(refClk), .rst(rst), .linkClk(linkClk),
        .sclIn(sclM), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrStrapPins(3'h5), .portPinsIn(pins), .portPinsOut(pinOut),
        .portPinsOe(pinOe), .intOut(intOut), .intOe(intOe));
    gpx_bus_master u_mst (.clk(refClk), .sda(sdaW), .scl(sclM),
        .sdaLow(sdaLow));
    task automatic w();
        repeat (20) @(posedge refClk);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, d);
        u_mst.start();
        u_mst.xfer({a, 2'b01}, rx);
        check({7'h0, rx[0]}, {7'h0, a != ADDR});
        u_mst.xfer({c, 1'b1}, rx);
        u_mst.xfer({d, 1'b1}, rx);
        check({7'h0, rx[0]}, {7'h0, a != ADDR});
        u_mst.stop();
        w();
    endtask
    task automatic rd(input logic [7:0] c, exp, input logic newCmd);
        if (newCmd) begin
            u_mst.start();
            u_mst.xfer({ADDR, 2'b01}, rx);
            u_mst.xfer({c, 1'b1}, rx);
        end
        u_mst.start();
        u_mst.xfer({ADDR, 2'b11}, rx);
        u_mst.xfer(9'h1ff, rx);
        u_mst.stop();
        check(rx[8:1], exp);
        w();
    endtask
    task automatic t_defaults();
        check({7'h0, intN}, 8'h01);
        rd(8'h01, 8'hff, 1'b1);
        rd(8'h02, 8'h00, 1'b1);
        rd(8'h03, 8'hff, 1'b1);
        rd(8'h00, 8'h3c, 1'b1);
        check(pinOe, 8'h00);
        $display("t_defaults done");
    endtask
    task automatic t_regs();
        wr(ADDR, 8'h01, 8'h5a);
        wr(ADDR, 8'h03, 8'h0f);
        check(pinOe, 8'hf0);
        check(pinOut & pinOe, 8'h50);
        rd(8'h00, 8'h5c, 1'b1);
        wr(ADDR, 8'h02, 8'hff);
        rd(8'h00, 8'ha3, 1'b1);
        wr(ADDR, 8'h00, 8'h00);
        rd(8'h00, 8'ha3, 1'b0);
        wr(7'h3c, 8'h01, 8'h00);
        rd(8'h01, 8'h5a, 1'b1);
        $display("t_regs done");
    endtask
    task automatic t_int();
        wr(ADDR, 8'h03, 8'hff);
        wr(ADDR, 8'h02, 8'h00);
        rd(8'h00, 8'h3c, 1'b1);
        ext = 8'h3d;
        w();
        check({7'h0, intN}, 8'h00);
        ext = 8'h3c;
        w();
        check({7'h0, intN}, 8'h01);
        ext = 8'h3e;
        w();
        wr(7'h3c, 8'h00, 8'h00);
        check({7'h0, intN}, 8'h00);
        rd(8'h00, 8'h3e, 1'b1);
        check({7'h0, intN}, 8'h01);
        wr(ADDR, 8'h03, 8'hfe);
        ext = 8'h3f;
        w();
        check({7'h0, intN}, 8'h01);
        wr(ADDR, 8'h03, 8'hff);
        check({7'h0, intN}, 8'h00);
        $display("t_int done");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Whole run needs about 1.03 ms; a hang is cut off well beyond it
    initial begin
        #3000000;
        errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge refClk);
        #1;
        rst = 1'b0;
        w();
        t_defaults();
        t_regs();
        t_int();
        conclude();
    end
endmodule // gpx_expander_test
